/* fan_loop_pkg.sv */
// Purpose: Shared constants and types of the automatic fan speed loop.
// Assumes: One 25 MHz clock, byte-wide register port.
// Notes:   Duty values are in PWM time slots, 240 slots per period.
`default_nettype none
package fan_loop_pkg;

   // ***************************************************
   // Clock and timing
   // ***************************************************
   localparam int CLK_PERIOD_NS    = 40;
   localparam int CLK_HZ           = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int MS_PER_S         = 1000;
   localparam int CHZ_PER_HZ       = 100;
   localparam int SLOTS_PER_PERIOD = 240;
   localparam int SPIN_MS  [8]     = '{200, 400, 600, 800, 1000, 2000, 4000, 8000};
   localparam int FREQ_CHZ [8]     = '{1170, 1560, 2340, 3125, 3750, 4690, 6250, 9350};

   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [7:0] ADDR_CFG1        = 8'h00;
   localparam logic [7:0] ADDR_FAN_TIMING  = 8'h20;
   localparam logic [7:0] ADDR_FLOOR       = 8'h22;
   localparam logic [7:0] ADDR_LOCAL_LOOP  = 8'h24;
   localparam logic [7:0] ADDR_REMOTE_LOOP = 8'h25;
   localparam logic [7:0] ADDR_MANUAL_DUTY = 8'h26;
   localparam logic [7:0] ADDR_STATUS      = 8'h27;
   localparam logic [7:0] ADDR_DUTY        = 8'h28;

   localparam logic [7:0] CFG1_RST         = 8'h80;
   localparam logic [7:0] FAN_TIMING_RST   = 8'h1d;
   localparam logic [7:0] FLOOR_RST        = 8'h05;
   localparam logic [7:0] LOCAL_LOOP_RST   = 8'hc0;
   localparam logic [7:0] REMOTE_LOOP_RST  = 8'h60;
   localparam logic [3:0] MANUAL_DUTY_RST  = 4'hf;

   // ***************************************************
   // Control loop figures
   // ***************************************************
   localparam logic [1:0] SEL_REMOTE       = 2'b00;
   localparam logic [1:0] SEL_FASTEST      = 2'b11;
   localparam int         NUM_CH           = 2;
   localparam int         CH_LOCAL         = 0;
   localparam int         CH_REMOTE        = 1;
   localparam logic [7:0] DUTY_FULL        = 8'hf0;
   localparam logic [3:0] TOP_DUTY_CODE    = 4'hf;
   localparam logic [2:0] SPAN_CODE_MAX    = 3'h4;
   localparam logic [7:0] SPAN_BASE_DEG    = 8'h05;
   localparam logic [7:0] HYST_DEG         = 8'h05;
   localparam logic [7:0] SPAN_DIVISOR     = 8'h0a;

   typedef struct packed {
      logic       auto_en;
      logic [1:0] ch_sel;
      logic [4:0] spare;
   } cfg1_t;

   typedef struct packed {
      logic [1:0] speed_range;
      logic [2:0] pwm_freq;
      logic [2:0] spin_code;
   } fan_timing_t;

   typedef struct packed {
      logic [3:0] spare;
      logic [3:0] floor_duty_code;
   } floor_cfg_t;

   typedef struct packed {
      logic [4:0] turn_on;
      logic [2:0] span_code;
   } loop_cfg_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_SPIN = 3'b010,
      ST_RUN  = 3'b100
   } fan_state_t;

endpackage
`default_nettype wire

/* auto_fan_speed_loop.sv */
// Purpose: Automatic fan speed loop: temperatures in, open-drain PWM out.
// Assumes: Temperatures come from logic on mclk, whole degrees C, unsigned.
// Notes:   Registers sit at their byte offsets on a plain strobe port.
//
// The implementer's own choice: the strobed register port.
`default_nettype none

// What this block does
// - Controlling temperature above turn-on point starts fan at floor duty, default 33%.
// - Every fan start runs a spin-up phase before temperature duty applies.
// - Three-bit code picks spin-up length 200 ms to 8 s, default 2 s.
// - Bit 7 of first configuration register set selects automatic control.
// - Automatic control is active from reset without any write.
// - Channel select 00 lets remote channel alone set the duty.
// - Channel select 11 drives the larger of local and remote duties.
// - Each channel uses its own turn-on point and control span.
// - Dual mode compares computed duties, never raw temperatures.
// - Duty at turn-on point comes from the floor duty field.
// - Floor code maps linearly, 0 is 0%, 15 is 100%.
// - Full duty reached at turn-on plus (15 - floor) times span over 10.
// - Between turn-on and full-speed points duty rises with temperature.
// - Running fan stops only 5 C below the turn-on point.
// - Clearing bit 7 hands duty to software; bit resets to one.
// - Turn-on in bits 7:3 at 4 C steps, span code in 2:0 doubling.
module auto_fan_speed_loop #(
   parameter int     CYC_PER_MS = fan_loop_pkg::CLK_HZ / fan_loop_pkg::MS_PER_S,
   parameter longint SLOT_NUM   = longint'(fan_loop_pkg::CLK_HZ) * fan_loop_pkg::CHZ_PER_HZ
                                  / fan_loop_pkg::SLOTS_PER_PERIOD
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_b,
   input  wire fan_loop_pkg::reg_req_t bus_req,
   output var  logic [7:0]             rdata,
   input  wire logic [7:0]             local_temp,
   input  wire logic [7:0]             remote_temp,
   output var  logic                   pwm_o,
   output var  logic                   pwm_oe
);
   import fan_loop_pkg::*;

   cfg1_t       cfg1_r;
   fan_timing_t timing_r;
   floor_cfg_t  floor_r;
   loop_cfg_t   loop_r [NUM_CH];
   logic [3:0]  manual_code_r;
   logic [7:0]  rd_mux;
   logic [7:0]  temp [NUM_CH];
   logic [7:0]  ch_duty [NUM_CH];
   logic [NUM_CH-1:0] ch_on;
   logic        want;
   logic [7:0]  ctrl_duty;
   fan_state_t  state_r;
   fan_state_t  state_nxt;
   logic [27:0] spin_cnt_r;
   logic [27:0] spin_len;
   logic [7:0]  duty_r;
   logic [7:0]  duty_nxt;
   logic [15:0] slot_div_r;
   logic [15:0] slot_len;
   logic [7:0]  slot_idx_r;

   assign temp[CH_LOCAL]  = local_temp;
   assign temp[CH_REMOTE] = remote_temp;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // ***************************************************
   // Register port
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cfg1_r           <= cfg1_t'(CFG1_RST);
         timing_r         <= fan_timing_t'(FAN_TIMING_RST);
         floor_r          <= floor_cfg_t'(FLOOR_RST);
         loop_r[CH_LOCAL] <= loop_cfg_t'(LOCAL_LOOP_RST);
         loop_r[CH_REMOTE] <= loop_cfg_t'(REMOTE_LOOP_RST);
         manual_code_r    <= MANUAL_DUTY_RST;
      end else if (bus_req.wr) begin
         case (bus_req.addr)
            ADDR_CFG1:        cfg1_r <= cfg1_t'(bus_req.wdata);
            ADDR_FAN_TIMING:  timing_r <= fan_timing_t'(bus_req.wdata);
            ADDR_FLOOR:       floor_r <= floor_cfg_t'(bus_req.wdata);
            ADDR_LOCAL_LOOP:  loop_r[CH_LOCAL] <= loop_cfg_t'(bus_req.wdata);
            ADDR_REMOTE_LOOP: loop_r[CH_REMOTE] <= loop_cfg_t'(bus_req.wdata);
            ADDR_MANUAL_DUTY: manual_code_r <= bus_req.wdata[3:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      case (bus_req.addr)
         ADDR_CFG1:        rd_mux = cfg1_r;
         ADDR_FAN_TIMING:  rd_mux = timing_r;
         ADDR_FLOOR:       rd_mux = floor_r;
         ADDR_LOCAL_LOOP:  rd_mux = loop_r[CH_LOCAL];
         ADDR_REMOTE_LOOP: rd_mux = loop_r[CH_REMOTE];
         ADDR_MANUAL_DUTY: rd_mux = {4'h0, manual_code_r};
         ADDR_STATUS:      rd_mux = {3'h0, ch_on, state_r};
         ADDR_DUTY:        rd_mux = duty_r;
         default:          rd_mux = 8'h00;
      endcase
   end

   // Data valid only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata <= 8'h00;
      end else begin
         rdata <= bus_req.rd ? rd_mux : 8'h00;
      end
   end

   // ***************************************************
   // Per-channel loops
   // ***************************************************
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic [7:0]  tmin_deg;
      logic [7:0]  delta;
      logic [2:0]  k;
      logic [7:0]  floor_slots;
      logic [13:0] raw;
      logic [7:0]  duty;
      logic        on_r;
      logic [15:0] lhs;
      logic [15:0] rhs;

      always_comb begin
         tmin_deg    = {1'b0, loop_r[i].turn_on, 2'b00};
         delta       = temp[i] - tmin_deg;
         // Codes past 80 C span reuse the widest slope
         k           = (loop_r[i].span_code > SPAN_CODE_MAX) ? SPAN_CODE_MAX : loop_r[i].span_code;
         floor_slots = {floor_r.floor_duty_code, 4'h0};
         // Span is 5 << k, so 160/span slots per degree is a shift
         raw         = 14'(floor_slots) + (14'({delta, 5'h00}) >> k);
         if (!on_r) begin
            duty = 8'h00;
         end else if (temp[i] <= tmin_deg) begin
            duty = floor_slots;
         end else if (raw >= 14'(DUTY_FULL)) begin
            duty = DUTY_FULL;
         end else begin
            duty = raw[7:0];
         end
      end

      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            on_r <= 1'b0;
         end else if (temp[i] > tmin_deg) begin
            on_r <= 1'b1;
         end else if ({1'b0, temp[i]} + {1'b0, HYST_DEG} <= {1'b0, tmin_deg}) begin
            on_r <= 1'b0;
         end
      end

      assign ch_duty[i] = duty;
      assign ch_on[i]   = on_r;

      // Independent form of the full-speed point, times ten
      assign lhs = 16'(delta) * 16'(SPAN_DIVISOR);
      assign rhs = 16'(TOP_DUTY_CODE - floor_r.floor_duty_code) * 16'(SPAN_BASE_DEG << k);

      property p_hyst;
         !on_r && (temp[i] <= tmin_deg) |=> !on_r;
      endproperty
      a_hyst: assert property (p_hyst) else $error("channel started at or below turn-on point");

      property p_keep_on;
         on_r && ({1'b0, temp[i]} + {1'b0, HYST_DEG} > {1'b0, tmin_deg}) |=> on_r;
      endproperty
      a_keep_on: assert property (p_keep_on) else $error("channel dropped inside hysteresis band");

      property p_floor;
         on_r && (temp[i] <= tmin_deg) |-> duty == {floor_r.floor_duty_code, 4'h0};
      endproperty
      a_floor: assert property (p_floor) else $error("duty at turn-on point is not floor");

      property p_full;
         on_r && (temp[i] > tmin_deg) && (lhs >= rhs) |-> duty == DUTY_FULL;
      endproperty
      a_full: assert property (p_full) else $error("full duty not reached at full-speed point");

      property p_slope;
         on_r && (temp[i] > tmin_deg) && (lhs < rhs) |-> duty < DUTY_FULL && duty >= floor_slots;
      endproperty
      a_slope: assert property (p_slope) else $error("duty outside floor to full range");

      property p_sat;
         duty == DUTY_FULL && temp[i] > tmin_deg ##1 temp[i] >= $past(temp[i]) && $stable(floor_r)
            && $stable(loop_r[i]) |-> duty == DUTY_FULL;
      endproperty
      a_sat: assert property (p_sat) else $error("channel left full duty while getting hotter");
   end

   // ***************************************************
   // Channel selection
   // ***************************************************
   // Codes 01 and 10 fall back to remote control
   always_comb begin
      if (cfg1_r.ch_sel == SEL_FASTEST) begin
         want      = |ch_on;
         ctrl_duty = (ch_duty[CH_LOCAL] > ch_duty[CH_REMOTE]) ? ch_duty[CH_LOCAL] : ch_duty[CH_REMOTE];
      end else begin
         want      = ch_on[CH_REMOTE];
         ctrl_duty = ch_duty[CH_REMOTE];
      end
   end

   // ***************************************************
   // Spin-up sequencer
   // ***************************************************
   assign spin_len = 28'(SPIN_MS[timing_r.spin_code] * CYC_PER_MS - 1);

   always_comb begin
      state_nxt = state_r;
      if (!cfg1_r.auto_en) begin
         state_nxt = ST_OFF;
      end else begin
         case (state_r)
            ST_OFF:  state_nxt = want ? ST_SPIN : ST_OFF;
            ST_SPIN: begin
               if (!want) begin
                  state_nxt = ST_OFF;
               end else if (spin_cnt_r == 28'h0) begin
                  state_nxt = ST_RUN;
               end
            end
            ST_RUN:  state_nxt = want ? ST_RUN : ST_OFF;
            default: state_nxt = ST_OFF;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_r <= ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         spin_cnt_r <= 28'h0;
      end else if (state_r == ST_OFF) begin
         spin_cnt_r <= spin_len;
      end else if (state_r == ST_SPIN && spin_cnt_r != 28'h0) begin
         spin_cnt_r <= spin_cnt_r - 28'h1;
      end
   end

   // ***************************************************
   // Applied duty
   // ***************************************************
   always_comb begin
      if (!cfg1_r.auto_en) begin
         duty_nxt = {manual_code_r, 4'h0};
      end else begin
         case (state_r)
            ST_SPIN: duty_nxt = DUTY_FULL;
            ST_RUN:  duty_nxt = ctrl_duty;
            default: duty_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         duty_r <= 8'h00;
      end else begin
         duty_r <= duty_nxt;
      end
   end

   // ***************************************************
   // PWM generator
   // ***************************************************
   assign slot_len = 16'(SLOT_NUM / longint'(FREQ_CHZ[timing_r.pwm_freq]) - 1);

   // Duty changes take effect at once, not at period end; a glitch here is harmless to a fan
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         slot_div_r <= 16'h0;
         slot_idx_r <= 8'h00;
      end else if (slot_div_r >= slot_len) begin
         slot_div_r <= 16'h0;
         slot_idx_r <= (slot_idx_r == DUTY_FULL - 8'h01) ? 8'h00 : slot_idx_r + 8'h01;
      end else begin
         slot_div_r <= slot_div_r + 16'h1;
      end
   end

   // Open drain: pull low outside the active slots, release for high
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pwm_o  <= 1'b0;
         pwm_oe <= 1'b1;
      end else begin
         pwm_o  <= 1'b0;
         pwm_oe <= !(slot_idx_r < duty_r);
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   sequence s_spin_start;
      state_r == ST_OFF && cfg1_r.auto_en && want;
   endsequence
   sequence s_spin_loaded;
      state_r == ST_SPIN && spin_cnt_r == $past(spin_len);
   endsequence

   property p_spin_load;
      s_spin_start |=> s_spin_loaded;
   endproperty
   a_spin_load: assert property (p_spin_load) else $error("spin-up not entered with programmed length");

   property p_spin_hold;
      state_r == ST_SPIN && cfg1_r.auto_en && want && spin_cnt_r != 28'h0 |=> state_r == ST_SPIN;
   endproperty
   a_spin_hold: assert property (p_spin_hold) else $error("spin-up left before its time");

   property p_run_entry;
      $rose(state_r == ST_RUN) |-> $past(state_r) == ST_SPIN && $past(spin_cnt_r) == 28'h0;
   endproperty
   a_run_entry: assert property (p_run_entry) else $error("run entered without full spin-up");

   property p_spin_full;
      state_r == ST_SPIN && cfg1_r.auto_en |=> duty_r == DUTY_FULL;
   endproperty
   a_spin_full: assert property (p_spin_full) else $error("spin-up duty not full");

   property p_auto_reset;
      $past(!rst_b) |-> cfg1_r.auto_en && cfg1_r.ch_sel == SEL_REMOTE && state_r == ST_OFF;
   endproperty
   a_auto_reset: assert property (p_auto_reset) else $error("automatic mode not active after reset");

   property p_manual;
      !cfg1_r.auto_en |=> duty_r == {$past(manual_code_r), 4'h0} && state_r == ST_OFF;
   endproperty
   a_manual: assert property (p_manual) else $error("software duty not applied");

   property p_remote_only;
      state_r == ST_RUN && cfg1_r.auto_en && cfg1_r.ch_sel == SEL_REMOTE |=> duty_r == $past(ch_duty[CH_REMOTE]);
   endproperty
   a_remote_only: assert property (p_remote_only) else $error("remote channel not in control");

   property p_fastest;
      state_r == ST_RUN && cfg1_r.auto_en && cfg1_r.ch_sel == SEL_FASTEST
         |=> duty_r >= $past(ch_duty[CH_LOCAL]) && duty_r >= $past(ch_duty[CH_REMOTE])
             && (duty_r == $past(ch_duty[CH_LOCAL]) || duty_r == $past(ch_duty[CH_REMOTE]));
   endproperty
   a_fastest: assert property (p_fastest) else $error("larger duty not driven");

   property p_pwm_full;
      duty_r == DUTY_FULL ##1 duty_r == DUTY_FULL |=> !pwm_oe;
   endproperty
   a_pwm_full: assert property (p_pwm_full) else $error("full duty pulled pin low");

   property p_pwm_zero;
      duty_r == 8'h00 ##1 duty_r == 8'h00 |=> pwm_oe && !pwm_o;
   endproperty
   a_pwm_zero: assert property (p_pwm_zero) else $error("zero duty released pin");
endmodule
`default_nettype wire

/* fan_model.sv */
// Purpose: Model of a PWM-driven cooling fan on the open-drain drive pin.
// Assumes: Pin has a pull-up; the fan runs while the pin is high.
// Notes:   Reports the length of the last completed high stretch.
`default_nettype none
module fan_model (
   input  wire logic mclk,
   input  wire logic pwm_o,
   input  wire logic pwm_oe,
   output wire logic fan_pin,
   output var  int   hi_len
);
   int hi_run = 0;

   // ************************************
   // Pin level
   // ************************************
   // Pull-up wins whenever the drain is off, never the last driven value
   assign fan_pin = pwm_oe ? pwm_o : 1'b1;

   // ************************************
   // High-time measurement
   // ************************************
   always @(posedge mclk) begin
      if (fan_pin === 1'b1) begin
         hi_run <= hi_run + 1;
      end else begin
         if (hi_run != 0) begin
            hi_len <= hi_run;
         end
         hi_run <= 0;
      end
   end
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench of the automatic fan speed loop.
// Assumes: Short spin-up and slot parameters keep the run brief.
// Notes:   Duty is judged through the readback register and the fan pin.
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fan_loop_pkg::*;

   // ************************************
   // Set-up
   // ************************************
   localparam int     CPM         = 2;
   localparam longint SLOT_N      = 11700;
   localparam int     SLOT_CYC    = int'(SLOT_N / FREQ_CHZ[3]);
   localparam int     TIMEOUT_CYC = 90000;

   logic       mclk;
   logic       rst_b;
   reg_req_t   bus_req;
   logic [7:0] rdata;
   logic [7:0] local_temp;
   logic [7:0] remote_temp;
   logic       pwm_o;
   logic       pwm_oe;
   wire logic  fan_pin;
   int         hi_len;
   int         bad_count   = 0;
   int         checks_done = 0;
   int         cyc         = 0;

   auto_fan_speed_loop #(.CYC_PER_MS(CPM), .SLOT_NUM(SLOT_N)) u_auto_fan_speed_loop (
      .mclk        (mclk),
      .rst_b       (rst_b),
      .bus_req     (bus_req),
      .rdata       (rdata),
      .local_temp  (local_temp),
      .remote_temp (remote_temp),
      .pwm_o       (pwm_o),
      .pwm_oe      (pwm_oe)
   );

   fan_model u_fan_model (
      .mclk    (mclk),
      .pwm_o   (pwm_o),
      .pwm_oe  (pwm_oe),
      .fan_pin (fan_pin),
      .hi_len  (hi_len)
   );

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Hang guard: far beyond the longest spin-up sweep
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == TIMEOUT_CYC) begin
         bad_count++;
         test_done();
      end
   end

   // ************************************
   // Helpers
   // ************************************
   task automatic test_done();
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      bus_req <= '0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      bus_req <= '0;
      #1 d = rdata;
   endtask

   task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      `CHK(what, e, d)
   endtask

   task automatic set_temps(input logic [7:0] l, input logic [7:0] r);
      @(posedge mclk);
      local_temp <= l;
      remote_temp <= r;
      repeat (4) @(posedge mclk);
   endtask

   // Slots from floor code, offset and span code
   function automatic logic [7:0] exp_duty(input int f, input int t, input int on, input int k);
      int span;
      int v;
      span = 5 << ((k > 4) ? 4 : k);
      v = (t <= on) ? f * 16 : f * 16 + ((t - on) * 160) / span;
      exp_duty = (v > 240) ? 8'hf0 : v[7:0];
   endfunction

   // Status polled every cycle so the spin length is exact to one clock
   task automatic spin_run(input logic [7:0] l, input logic [7:0] r, output int n, output int lows);
      logic [2:0] st;
      n = 0;
      lows = 0;
      @(posedge mclk);
      local_temp <= l;
      remote_temp <= r;
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: ADDR_STATUS, wdata: 8'h00};
      for (int i = 0; i < 20000; i++) begin
         @(posedge mclk);
         #1 st = rdata[2:0];
         if (st == ST_RUN) break;
         if (st == ST_SPIN) n++;
         // Pin lags the state by two edges
         if (st == ST_SPIN && n > 2 && fan_pin !== 1'b1) lows++;
      end
      @(posedge mclk);
      bus_req <= '0;
   endtask

   // ************************************
   // Scenarios
   // ************************************
   task automatic t_reset_values();
      `CHK("pin when cool", 1'b0, fan_pin)
      chk_reg("cfg1 reset", ADDR_CFG1, 8'h80);
      chk_reg("timing reset", ADDR_FAN_TIMING, FAN_TIMING_RST);
      chk_reg("floor reset", ADDR_FLOOR, 8'h05);
      chk_reg("remote loop reset", ADDR_REMOTE_LOOP, REMOTE_LOOP_RST);
      chk_reg("status idle", ADDR_STATUS, 8'h01);
      wr_reg(8'h50, 8'ha5);
      chk_reg("unmapped", 8'h50, 8'h00);
      wr_reg(ADDR_DUTY, 8'h77);
      chk_reg("duty read only", ADDR_DUTY, 8'h00);
      wr_reg(ADDR_FLOOR, 8'h0b);
      chk_reg("floor write", ADDR_FLOOR, 8'h0b);
      wr_reg(ADDR_FLOOR, 8'h05);
   endtask

   task automatic t_spin_table();
      int n;
      int lows;
      int e;
      for (int c = 0; c < 8; c++) begin
         wr_reg(ADDR_FAN_TIMING, {5'h03, 3'(c)});
         spin_run(8'h00, 8'd49, n, lows);
         e = SPIN_MS[c] * CPM;
         `CHK("spin length", 1'b1, (n >= e - 1) && (n <= e + 1))
         `CHK("pin low in spin", 0, lows)
         chk_reg("duty after spin", ADDR_DUTY, exp_duty(5, 49, 48, 0));
         set_temps(8'h00, 8'd44);
         chk_reg("held in band", ADDR_DUTY, exp_duty(5, 44, 48, 0));
         set_temps(8'h00, 8'd43);
         chk_reg("off below band", ADDR_DUTY, 8'h00);
      end
   endtask

   task automatic t_curve();
      int n;
      int lows;
      int temps [5] = '{48, 50, 57, 90, 200};
      wr_reg(ADDR_FAN_TIMING, 8'h18);
      spin_run(8'h00, 8'd60, n, lows);
      for (int f = 0; f < 16; f++) begin
         wr_reg(ADDR_FLOOR, 8'(f));
         for (int k = 0; k < 6; k++) begin
            wr_reg(ADDR_REMOTE_LOOP, {5'h0c, 3'(k)});
            for (int i = 0; i < 5; i++) begin
               set_temps(8'h00, 8'(temps[i]));
               chk_reg("curve duty", ADDR_DUTY, exp_duty(f, temps[i], 48, k));
            end
         end
      end
      wr_reg(ADDR_FLOOR, 8'h05);
      wr_reg(ADDR_REMOTE_LOOP, 8'h60);
      set_temps(8'h00, 8'd49);
      repeat (1500) @(posedge mclk);
      `CHK("pin high time", int'(exp_duty(5, 49, 48, 0)) * SLOT_CYC, hi_len)
      // Slowest PWM rate: same duty, longer slots
      wr_reg(ADDR_FAN_TIMING, 8'h00);
      repeat (4000) @(posedge mclk);
      `CHK("pin high time slow", int'(exp_duty(5, 49, 48, 0)) * int'(SLOT_N / FREQ_CHZ[0]), hi_len)
   endtask

   task automatic t_dual();
      int l [4] = '{40, 20, 60, 58};
      int r [4] = '{40, 20, 70, 70};
      logic [7:0] a;
      logic [7:0] b;
      wr_reg(ADDR_LOCAL_LOOP, 8'h2b);
      wr_reg(ADDR_REMOTE_LOOP, 8'h04);
      wr_reg(ADDR_CFG1, 8'he0);
      for (int i = 0; i < 4; i++) begin
         set_temps(8'(l[i]), 8'(r[i]));
         a = exp_duty(5, l[i], 20, 3);
         b = exp_duty(5, r[i], 0, 4);
         chk_reg("fastest duty", ADDR_DUTY, (a > b) ? a : b);
      end
      wr_reg(ADDR_CFG1, 8'h80);
      set_temps(8'd58, 8'd70);
      chk_reg("remote only", ADDR_DUTY, b);
      // Select codes 01 and 10 fall back to remote control
      wr_reg(ADDR_CFG1, 8'ha0);
      chk_reg("select 01 remote", ADDR_DUTY, b);
      wr_reg(ADDR_CFG1, 8'hc0);
      chk_reg("select 10 remote", ADDR_DUTY, b);
   endtask

   task automatic t_manual();
      int n;
      int lows;
      wr_reg(ADDR_MANUAL_DUTY, 8'h07);
      wr_reg(ADDR_CFG1, 8'h60);
      set_temps(8'h00, 8'h00);
      chk_reg("manual duty", ADDR_DUTY, 8'h70);
      wr_reg(ADDR_REMOTE_LOOP, 8'h60);
      wr_reg(ADDR_FAN_TIMING, 8'h18);
      wr_reg(ADDR_CFG1, 8'h80);
      set_temps(8'h00, 8'h00);
      chk_reg("auto cool", ADDR_DUTY, 8'h00);
      spin_run(8'h00, 8'd49, n, lows);
      `CHK("spin on enable", 1'b1, (n >= 399) && (n <= 401))
   endtask

   task automatic t_mid_reset();
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      chk_reg("timing after reset", ADDR_FAN_TIMING, FAN_TIMING_RST);
      chk_reg("manual after reset", ADDR_MANUAL_DUTY, {4'h0, MANUAL_DUTY_RST});
      chk_reg("cfg1 after reset", ADDR_CFG1, CFG1_RST);
   endtask

   initial begin
      rst_b = 1'b0;
      bus_req = '0;
      local_temp = 8'h00;
      remote_temp = 8'h00;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset_values();
      t_spin_table();
      t_curve();
      t_dual();
      t_manual();
      t_mid_reset();
      test_done();
   end
endmodule
`default_nettype wire
